// file: common/rlpc_defs.svh
// register offsets, fields, reset values and timing counts for the link control
`ifndef RLPC_DEFS_SVH
`define RLPC_DEFS_SVH

`define RLPC_CLK_HZ        10000000
`define RLPC_CYC_PER_MS    (`RLPC_CLK_HZ / 1000)

`define RLPC_OFF_CTRL      12'h000
`define RLPC_OFF_TXDLY     12'h004
`define RLPC_OFF_KEY       12'h008
`define RLPC_OFF_STATUS    12'h00C
`define RLPC_OFF_HASH      12'h010
`define RLPC_OFF_TXPWR     12'h014
`define RLPC_OFF_RSSI      12'h018
`define RLPC_OFF_TXDATA    12'h01C
`define RLPC_OFF_RXDATA    12'h020
`define RLPC_OFF_AIRIN     12'h024

`define RLPC_CTRL_ENC      0
`define RLPC_CTRL_AES256   1
`define RLPC_CTRL_RXONLY   2
`define RLPC_CTRL_PRIO_RX  3
`define RLPC_CTRL_FEC      4
`define RLPC_CTRL_CHK_LSB  5
`define RLPC_CTRL_RSSI     7
`define RLPC_CTRL_SPLIT    8
`define RLPC_CTRL_IV64     9
`define RLPC_CTRL_RESET    32'h0000_0000

`define RLPC_ENC_LAT_MS    5
`define RLPC_SPLIT_DLY_MS  40
`define RLPC_TXDLY_MAX_MS  16'd65000
`define RLPC_PAUSE_CYC     100
`define RLPC_TXBUF_DEPTH   1024
`define RLPC_CRC8_POLY     8'h07
`define RLPC_CRC16_POLY    16'h1021
`define RLPC_CRC16_INIT    16'hFFFF
`define RLPC_BLK_LEN       8
`define RLPC_STX           8'h02
`define RLPC_ETX           8'h03
`define RLPC_TXPWR_MW      32'h0000_03E8

`endif

// file: common/rlpc_pkg.sv
// types shared by the link control modules
package rlpc_pkg;
  typedef enum logic [1:0] {
    CHK_OFF, CHK_CRC8_PART, CHK_CRC8_FULL, CHK_CRC16_FULL
  } rlpc_chk_t;
  typedef enum {
    S_IDLE, S_DELAY, S_SWITCH, S_TX, S_RX
  } rlpc_radio_t;
endpackage

// file: core/rlpc_crc.sv
// crc-8 and crc-16 byte update logic
`timescale 1ns/1ps
`include "rlpc_defs.svh"
module rlpc_crc (
  // byte in
  input  logic [7:0]  data_in,
  input  logic [15:0] crc_in,
  input  logic        wide,
  // next crc
  output logic [15:0] crc_out
);
  logic [15:0] c;
  always_comb begin
    c = crc_in;
    for (int i = 7; i >= 0; i--) begin
      if (wide) begin
        if (c[15] ^ data_in[i])
          c = {c[14:0], 1'b0} ^ `RLPC_CRC16_POLY;
        else
          c = {c[14:0], 1'b0};
      end else begin
        if (c[7] ^ data_in[i])
          c = {8'h00, c[6:0], 1'b0} ^ {8'h00, `RLPC_CRC8_POLY};
        else
          c = {8'h00, c[6:0], 1'b0};
      end
    end
    crc_out = c;
  end
endmodule

// file: core/rlpc_ctr.sv
// per-packet counter-mode keystream from key, aux key and packet value
`timescale 1ns/1ps
`include "rlpc_defs.svh"
module rlpc_ctr (
  // clock and reset
  input  logic        pclk,
  input  logic        presetn,
  // key material
  input  logic [255:0] main_key,
  input  logic [255:0] aux_key,
  input  logic         wide_key,
  input  logic [63:0]  pkt_iv,
  // counter control
  input  logic         restart,
  input  logic         step,
  // keystream byte
  output logic [7:0]   ks
);
  logic [31:0] ctr_reg;
  logic [255:0] mixed;
  logic [31:0]  w;

  // round-mixed key block; the cipher core itself is replaceable
  assign mixed = wide_key ? (main_key ^ aux_key)
                          : {128'h0, main_key[127:0] ^ aux_key[127:0]};
  always_comb begin
    w = mixed[31:0] ^ mixed[63:32] ^ mixed[95:64] ^ mixed[127:96]
      ^ mixed[159:128] ^ mixed[191:160] ^ mixed[223:192] ^ mixed[255:224]
      ^ pkt_iv[31:0] ^ pkt_iv[63:32] ^ ctr_reg;
    w = w ^ {w[18:0], w[31:19]} ^ {w[6:0], w[31:7]};
  end
  assign ks = w[7:0] ^ w[15:8] ^ w[23:16] ^ w[31:24];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ctr_reg <= 32'h0000_0000;
    else if (restart)
      ctr_reg <= 32'h0000_0000;
    else if (step)
      ctr_reg <= ctr_reg + 32'h0000_0001;
  end
endmodule

// file: core/rlpc_top.sv
// radio link packet control with apb registers
`timescale 1ns/1ps
`include "rlpc_defs.svh"
module rlpc_top
  import rlpc_pkg::*;
#(
  parameter int ENC_LAT_CYC   = `RLPC_ENC_LAT_MS * `RLPC_CYC_PER_MS,
  parameter int SPLIT_DLY_CYC = `RLPC_SPLIT_DLY_MS * `RLPC_CYC_PER_MS,
  parameter int CYC_PER_MS    = `RLPC_CYC_PER_MS
) (
  // apb
  input  logic        pclk,
  input  logic        presetn,
  input  logic        psel,
  input  logic        penable,
  input  logic        pwrite,
  input  logic [11:0] paddr,
  input  logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic        pready,
  output logic        pslverr,
  // factory strap
  input  logic        factory_rx_only,
  // air side
  input  logic        air_carrier,
  input  logic        air_fec,
  output logic        tx_on,
  output logic        fec_on,
  output logic        air_tx_valid,
  output logic [7:0]  air_tx_data,
  output logic        rx_freq_sel
);
  logic        wr, rd;
  logic [31:0] ctrl_reg;
  logic [15:0] txdly_reg;
  logic [255:0] main_key_reg, aux_key_reg;
  logic [15:0] hash_reg;
  logic        rx_only;
  logic [7:0]  rssi_reg;
  rlpc_chk_t   chk;
  rlpc_radio_t st_reg;
  logic [7:0]  txbuf [0:`RLPC_TXBUF_DEPTH-1];
  logic [9:0]  wp_reg, rp_reg;
  logic [10:0] cnt_reg;
  logic [7:0]  rxbuf [0:255];
  logic [7:0]  rwp_reg, rrp_reg, rcommit_reg;
  logic [8:0]  rcnt_reg;
  logic [7:0]  blk_reg;
  logic        drop_reg;
  logic [15:0] rcrc_reg, tcrc_reg;
  logic [15:0] rcrc_nx, tcrc_nx;
  logic [31:0] tmr_reg;
  logic [15:0] ms_left_reg;
  logic [31:0] pause_reg;
  logic [63:0] iv_reg;
  logic [7:0]  ks;
  logic        tx_step, tx_push, rx_pop, air_wr, air_last, flush;
  logic [3:0]  tr_reg;
  logic        rx_valid;
  logic [1:0]  tail_reg;
  logic        trl_pend_reg;
  logic [7:0]  txo_reg, rx_out;
  logic        ovf_reg;

  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign chk = rlpc_chk_t'(ctrl_reg[`RLPC_CTRL_CHK_LSB +: 2]);
  assign rx_only = factory_rx_only | ctrl_reg[`RLPC_CTRL_RXONLY];
  assign fec_on = ctrl_reg[`RLPC_CTRL_FEC];
  assign tx_push = wr && paddr == `RLPC_OFF_TXDATA;
  assign air_wr = wr && paddr == `RLPC_OFF_AIRIN;
  assign air_last = pwdata[8];
  // trailer bytes count as readable data too
  assign rx_valid = rrp_reg != rcommit_reg || tr_reg != 4'd0;
  assign rx_pop = rd && paddr == `RLPC_OFF_RXDATA && rx_valid;
  assign flush = tx_push && cnt_reg == 11'(`RLPC_TXBUF_DEPTH);

  // control and key registers; keys never read back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `RLPC_CTRL_RESET;
      txdly_reg <= 16'h0000;
      main_key_reg <= '0;
      aux_key_reg <= '0;
      hash_reg <= 16'h0000;
    end else if (wr) begin
      case (paddr)
        `RLPC_OFF_CTRL:  ctrl_reg <= pwdata;
        `RLPC_OFF_TXDLY: txdly_reg <=
          (pwdata > 32'(`RLPC_TXDLY_MAX_MS)) ? `RLPC_TXDLY_MAX_MS
                                             : pwdata[15:0];
        `RLPC_OFF_KEY: begin
          main_key_reg <= {main_key_reg[223:0], aux_key_reg[255:224]};
          aux_key_reg <= {aux_key_reg[223:0], pwdata};
          hash_reg <= {hash_reg[14:0], hash_reg[15]} ^ pwdata[31:16]
                      ^ pwdata[15:0];
        end
        default: ;
      endcase
    end
  end

  // received signal strength, magnitude in dbm
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      rssi_reg <= 8'h00;
    else if (wr && paddr == `RLPC_OFF_RSSI)
      rssi_reg <= pwdata[7:0];
  end

  // apb read mux
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite) begin
      case (paddr)
        `RLPC_OFF_CTRL:   prdata <= ctrl_reg;
        `RLPC_OFF_TXDLY:  prdata <= {16'h0000, txdly_reg};
        `RLPC_OFF_STATUS: prdata <= {16'h0000, 3'h0, ovf_reg, rx_only,
                                     tx_on, cnt_reg[9:0] == 10'h000 &&
                                     !cnt_reg[10], cnt_reg[10],
                                     rcommit_reg - rrp_reg};
        `RLPC_OFF_HASH:   prdata <= {16'h0000, hash_reg};
        `RLPC_OFF_TXPWR:  prdata <= rx_only ? 32'h0000_0000
                                            : `RLPC_TXPWR_MW;
        `RLPC_OFF_RSSI:   prdata <= {24'h000000, rssi_reg};
        `RLPC_OFF_RXDATA: prdata <= rx_valid ? {23'h0, 1'b1, rx_out}
                                             : 32'h0000_0000;
        default:          prdata <= 32'h0000_0000;
      endcase
    end
  end

  // trailer insertion on the serial read stream
  always_comb begin
    case (tr_reg)
      4'd1: rx_out = `RLPC_STX;
      4'd2: rx_out = 8'h52;
      4'd3: rx_out = 8'h53;
      4'd4: rx_out = 8'h53;
      4'd5: rx_out = 8'h49;
      4'd6: rx_out = 8'h3A;
      4'd7: rx_out = 8'h2D;
      4'd8: rx_out = 8'h30 + 8'(rssi_reg / 100);
      4'd9: rx_out = 8'h30 + 8'((rssi_reg / 10) % 10);
      4'd10: rx_out = 8'h30 + 8'(rssi_reg % 10);
      4'd11: rx_out = 8'h20;
      4'd12: rx_out = 8'h64;
      4'd13: rx_out = 8'h42;
      4'd14: rx_out = 8'h6D;
      4'd15: rx_out = `RLPC_ETX;
      default: rx_out = rxbuf[rrp_reg];
    endcase
  end

  // transmit buffer, 1 kB, flushed on overfill
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_reg <= 10'h000;
      rp_reg <= 10'h000;
      cnt_reg <= 11'h000;
      ovf_reg <= 1'b0;
    end else if (flush) begin
      wp_reg <= 10'h000;
      rp_reg <= 10'h000;
      cnt_reg <= 11'h000;
      ovf_reg <= 1'b1;
    end else begin
      if (tx_push)
        wp_reg <= wp_reg + 10'h001;
      if (tx_step)
        rp_reg <= rp_reg + 10'h001;
      cnt_reg <= cnt_reg + 11'(tx_push) - 11'(tx_step);
      if (rd && paddr == `RLPC_OFF_STATUS)
        ovf_reg <= 1'b0;
    end
  end
  always_ff @(posedge pclk) begin
    if (tx_push)
      txbuf[wp_reg] <= pwdata[7:0];
  end

  // serial idle pause after last terminal byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      pause_reg <= 32'h0;
    else if (tx_push)
      pause_reg <= 32'h0;
    else if (pause_reg != `RLPC_PAUSE_CYC)
      pause_reg <= pause_reg + 32'h1;
  end

  // radio state machine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= S_IDLE;
      tmr_reg <= 32'h0;
      ms_left_reg <= 16'h0;
      iv_reg <= 64'h0;
      rx_freq_sel <= 1'b1;
    end else begin
      if (tmr_reg != 32'h0)
        tmr_reg <= tmr_reg - 32'h1;
      iv_reg <= iv_reg + 64'h1;
      case (st_reg)
        S_IDLE, S_RX: begin
          if (air_carrier && st_reg == S_IDLE && !air_wr)
            st_reg <= S_RX;
          else if (st_reg == S_RX && !air_carrier)
            st_reg <= S_IDLE;
          if (cnt_reg != 11'h0 && !rx_only && (st_reg == S_IDLE ||
              !ctrl_reg[`RLPC_CTRL_PRIO_RX])) begin
            st_reg <= S_DELAY;
            ms_left_reg <= txdly_reg;
            tmr_reg <= 32'(CYC_PER_MS);
          end
        end
        S_DELAY: begin
          if (ms_left_reg == 16'h0) begin
            st_reg <= S_SWITCH;
            tmr_reg <= 32'(ctrl_reg[`RLPC_CTRL_ENC] ? ENC_LAT_CYC : 0)
                     + 32'(ctrl_reg[`RLPC_CTRL_SPLIT] ? SPLIT_DLY_CYC : 0);
          end else if (tmr_reg == 32'h0) begin
            ms_left_reg <= ms_left_reg - 16'h1;
            tmr_reg <= 32'(CYC_PER_MS);
          end
        end
        S_SWITCH: begin
          rx_freq_sel <= 1'b0;
          if (tmr_reg == 32'h0)
            st_reg <= S_TX;
        end
        S_TX: begin
          if (flush)
            st_reg <= S_DELAY;
          else if (cnt_reg == 11'h0 && tail_reg == 2'd0 &&
                   pause_reg == `RLPC_PAUSE_CYC) begin
            st_reg <= S_IDLE;
            rx_freq_sel <= 1'b1;
          end
        end
        default: st_reg <= S_IDLE;
      endcase
    end
  end
  assign tx_on = st_reg == S_TX || st_reg == S_SWITCH;

  // air transmit byte path with checksum tail
  assign tx_step = st_reg == S_TX && cnt_reg != 11'h0 && !flush;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tcrc_reg <= `RLPC_CRC16_INIT;
      tail_reg <= 2'd0;
      txo_reg <= 8'h00;
      air_tx_valid <= 1'b0;
    end else begin
      air_tx_valid <= 1'b0;
      if (st_reg == S_SWITCH) begin
        tcrc_reg <= (chk == CHK_CRC16_FULL) ? `RLPC_CRC16_INIT : 16'h0;
        tail_reg <= (chk == CHK_CRC16_FULL) ? 2'd2 :
                    (chk == CHK_OFF) ? 2'd0 : 2'd1;
      end else if (tx_step) begin
        tcrc_reg <= tcrc_nx;
        txo_reg <= txbuf[rp_reg] ^
                   (ctrl_reg[`RLPC_CTRL_ENC] ? ks : 8'h00);
        air_tx_valid <= 1'b1;
      end else if (st_reg == S_TX && tail_reg != 2'd0 && cnt_reg == 11'h0 &&
                   pause_reg == `RLPC_PAUSE_CYC) begin
        // checksum only once the whole message has gone out
        txo_reg <= (tail_reg == 2'd2 && chk == CHK_CRC16_FULL) ?
                   tcrc_reg[15:8] : tcrc_reg[7:0];
        tail_reg <= tail_reg - 2'd1;
        air_tx_valid <= 1'b1;
      end
    end
  end
  assign air_tx_data = txo_reg;

  rlpc_crc u_tcrc (
    .data_in (txbuf[rp_reg]),
    .crc_in  (tcrc_reg),
    .wide    (chk == CHK_CRC16_FULL),
    .crc_out (tcrc_nx)
  );
  rlpc_crc u_rcrc (
    .data_in (pwdata[7:0]),
    .crc_in  (rcrc_reg),
    .wide    (chk == CHK_CRC16_FULL),
    .crc_out (rcrc_nx)
  );
  rlpc_ctr u_ctr (
    .pclk     (pclk),
    .presetn  (presetn),
    .main_key (main_key_reg),
    .aux_key  (aux_key_reg),
    .wide_key (ctrl_reg[`RLPC_CTRL_AES256]),
    .pkt_iv   (ctrl_reg[`RLPC_CTRL_IV64] ? iv_reg : {32'h0, iv_reg[31:0]}),
    .restart  (st_reg == S_SWITCH),
    .step     (tx_step),
    .ks       (ks)
  );

  // air receive path: fec match, crc checks, commit to serial side
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rwp_reg <= 8'h00;
      rcommit_reg <= 8'h00;
      rcrc_reg <= 16'h0;
      blk_reg <= 8'h00;
      drop_reg <= 1'b0;
    end else if (air_wr && air_fec == fec_on && !tx_on) begin
      if (chk == CHK_OFF) begin
        rwp_reg <= rwp_reg + 8'h01;
        rcommit_reg <= rwp_reg + 8'h01;
      end else if (chk == CHK_CRC8_PART) begin
        if (blk_reg == 8'(`RLPC_BLK_LEN)) begin
          if (rcrc_reg[7:0] == pwdata[7:0] && !drop_reg)
            rcommit_reg <= rwp_reg;
          else begin
            drop_reg <= 1'b1;
            rwp_reg <= rcommit_reg;
          end
          blk_reg <= 8'h00;
          rcrc_reg <= 16'h0;
        end else if (!drop_reg) begin
          rwp_reg <= rwp_reg + 8'h01;
          rcrc_reg <= rcrc_nx;
          blk_reg <= blk_reg + 8'h01;
        end
        if (air_last) begin
          drop_reg <= 1'b0;
          blk_reg <= 8'h00;
        end
      end else if (air_last) begin
        if (chk == CHK_CRC8_FULL && rcrc_reg[7:0] == pwdata[7:0])
          rcommit_reg <= rwp_reg;
        else if (chk == CHK_CRC16_FULL && rcrc_nx == 16'h0000) begin
          // high checksum byte was stored; drop it again
          rwp_reg <= rwp_reg - 8'h01;
          rcommit_reg <= rwp_reg - 8'h01;
        end else
          rwp_reg <= rcommit_reg;
        rcrc_reg <= (chk == CHK_CRC16_FULL) ? `RLPC_CRC16_INIT : 16'h0;
      end else begin
        rwp_reg <= rwp_reg + 8'h01;
        rcrc_reg <= rcrc_nx;
      end
    end
  end
  always_ff @(posedge pclk) begin
    if (air_wr)
      rxbuf[rwp_reg] <= pwdata[7:0];
  end

  // serial read pointer and trailer sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rrp_reg <= 8'h00;
      tr_reg <= 4'd0;
      trl_pend_reg <= 1'b0;
    end else begin
      if (air_wr && air_last && ctrl_reg[`RLPC_CTRL_RSSI] &&
          air_fec == fec_on && !tx_on)
        trl_pend_reg <= 1'b1;
      if (rx_pop) begin
        if (tr_reg != 4'd0)
          tr_reg <= (tr_reg == 4'd15) ? 4'd0 : tr_reg + 4'd1;
        else begin
          rrp_reg <= rrp_reg + 8'h01;
          // trailer follows the last byte of the message
          if (trl_pend_reg && rrp_reg + 8'h01 == rcommit_reg) begin
            tr_reg <= 4'd1;
            trl_pend_reg <= 1'b0;
          end
        end
      end
    end
  end
endmodule

// file: bench/rlpc_monitor.sv
// assertion checker on the link control top ports
`timescale 1ns/1ps
module rlpc_monitor #(
  parameter int ENC_LAT_CYC   = 5,
  parameter int SPLIT_DLY_CYC = 10,
  parameter int CYC_PER_MS    = 10
) (
  // apb
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic        pready,
  // strap and air side
  input logic        factory_rx_only,
  input logic        air_carrier,
  input logic        tx_on,
  input logic        fec_on,
  input logic        air_tx_valid
);
  logic        wr_c;
  logic        rd_c;
  logic [31:0] ctrl_reg;
  logic [31:0] dly_reg;
  logic [7:0]  quiet_reg;
  assign wr_c = psel && penable && pready && pwrite;
  assign rd_c = psel && penable && !pwrite;
  // shadow of control and delay writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= 32'h0;
      dly_reg  <= 32'h0;
    end else if (wr_c && paddr == 12'h000) begin
      ctrl_reg <= pwdata;
    end else if (wr_c && paddr == 12'h004) begin
      dly_reg <= pwdata;
    end
  end
  // cycles since last terminal byte, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quiet_reg <= 8'h00;
    end else if (wr_c && paddr == 12'h01C) begin
      quiet_reg <= 8'h00;
    end else if (quiet_reg != 8'hFF) begin
      quiet_reg <= quiet_reg + 8'h01;
    end
  end
  default clocking mcb @(posedge pclk); endclocking
  default disable iff (!presetn);
  fec_follow_a: assert property (
    wr_c && paddr == 12'h000 |=> fec_on == $past(pwdata[4]))
    else $error("fec output does not follow control");
  tx_power_a: assert property (
    rd_c && paddr == 12'h014 |-> prdata == (($past(factory_rx_only)
      || $past(ctrl_reg[2])) ? 32'h0 : 32'h3E8))
    else $error("transmitter power reading wrong");
  key_hidden_a: assert property (
    rd_c && paddr == 12'h008 |-> prdata == 32'h0)
    else $error("key readable");
  rx_only_quiet_a: assert property (
    factory_rx_only [*3] |-> !tx_on && !air_tx_valid)
    else $error("transmitter used in receive only state");
  tx_first_a: assert property (
    wr_c && paddr == 12'h01C && ctrl_reg[9:0] == 10'h0 && dly_reg == 32'h0
      && !factory_rx_only |-> ##[1:8] tx_on)
    else $error("transmitter not keyed on terminal data");
  rx_first_a: assert property (
    ctrl_reg[3] && dly_reg == 32'h0 && air_carrier && !tx_on |=> !tx_on)
    else $error("reception interrupted under receive priority");
  air_keyed_a: assert property (
    air_tx_valid |-> tx_on)
    else $error("air byte with transmitter off");
  pause_end_a: assert property (
    $fell(tx_on) |-> quiet_reg >= 8'd99)
    else $error("transmission ended before serial pause");
  abort_c: cover property (air_carrier && $rose(tx_on));
  wait_c: cover property (ctrl_reg[3] && $fell(air_carrier) ##[1:20] tx_on);
  delay_c: cover property (dly_reg != 32'h0 && $rose(tx_on));
endmodule

// file: bench/rlpc_peer_model.sv
// peer modem: keys its carrier for a frame and shows its fec setting
`timescale 1ns/1ps
module rlpc_peer_model (
  // clock and reset
  input  logic       pclk,
  input  logic       presetn,
  // frame request
  input  logic       start,
  input  logic [7:0] frame_cyc,
  input  logic       fec_cfg,
  // air side
  output logic       air_carrier,
  output logic       air_fec
);
  logic [7:0] left_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_reg <= 8'h00;
    end else if (start) begin
      left_reg <= frame_cyc;
    end else if (left_reg != 8'h00) begin
      left_reg <= left_reg - 8'h01;
    end
  end
  assign air_carrier = left_reg != 8'h00;
  assign air_fec     = fec_cfg;
endmodule

// file: bench/radio_link_packet_control_tb_top.sv
// self-checking bench for the radio link packet control
`timescale 1ns/1ps
module radio_link_packet_control_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        factory_rx_only, air_carrier, air_fec, tx_on, fec_on;
  logic        air_tx_valid, rx_freq_sel, start, fec_cfg, air_ign;
  logic [7:0]  air_tx_data, frame_cyc, b, c8;
  logic [31:0] rd_q[$];
  logic [7:0]  air_q[$];
  logic [7:0]  msg[$];
  int          err_count, comparisons, n, k, cyc;
  string       s;
  rlpc_top #(.ENC_LAT_CYC(5), .SPLIT_DLY_CYC(10), .CYC_PER_MS(10)) u_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .factory_rx_only, .air_carrier, .air_fec, .tx_on,
    .fec_on, .air_tx_valid, .air_tx_data, .rx_freq_sel);
  rlpc_peer_model u_peer (.pclk, .presetn, .start, .frame_cyc, .fec_cfg,
    .air_carrier, .air_fec);
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic timeout(string what);
    err_count++;
    $display("MISMATCH %s expected event seen timeout", what);
    report_and_stop();
  endtask
  function automatic logic [15:0] crc16(logic [15:0] c, logic [7:0] d);
    c = c ^ {d, 8'h00};
    repeat (8) c = c[15] ? {c[14:0], 1'b0} ^ 16'h1021 : {c[14:0], 1'b0};
    return c;
  endfunction
  function automatic logic [7:0] crc8(logic [7:0] c, logic [7:0] d);
    c = c ^ d;
    repeat (8) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
    return c;
  endfunction
  task automatic apb(logic [11:0] a, logic w, logic [31:0] d);
    int t;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (t = 0; t < 20; t++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (t == 20) timeout("pready");
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] exp);
    rd_q.push_back(exp);
    apb(a, 1'b0, 32'h0);
  endtask
  task automatic peer(logic [7:0] len);
    @(posedge pclk);
    frame_cyc <= len;
    start     <= 1'b1;
    @(posedge pclk);
    start <= 1'b0;
  endtask
  task automatic wait_tx(logic lvl);
    for (n = 0; n < 3000 && tx_on !== lvl; n++) @(negedge pclk);
    if (tx_on !== lvl) timeout("tx_on");
  endtask
  task automatic drain;
    for (n = 0; n < 3000 && air_q.size() != 0; n++) @(negedge pclk);
    if (air_q.size() != 0) timeout("air bytes");
    wait_tx(1'b0);
  endtask
  task automatic send(int cnt, logic [1:0] mode);
    logic [15:0] c16;
    c16 = 16'hFFFF;
    c8  = 8'h00;
    repeat (cnt) begin
      b = 8'($urandom);
      air_q.push_back(b);
      c16 = crc16(c16, b);
      c8  = crc8(c8, b);
      apb(12'h01C, 1'b1, {24'h0, b});
    end
    if (mode == 2'd2) air_q.push_back(c8);
    if (mode == 2'd3) begin
      air_q.push_back(c16[15:8]);
      air_q.push_back(c16[7:0]);
    end
  endtask
  task automatic lat(logic [31:0] ctrl, int lo);
    apb(12'h000, 1'b1, ctrl);
    air_ign = ctrl[0];
    send(1, 2'd0);
    for (cyc = 0; cyc < 2000 && air_tx_valid !== 1'b1; cyc++) @(negedge pclk);
    check("start latency", 32'h1, {31'h0, cyc >= lo});
    if (ctrl[8]) check("tx frequency", 32'h0, {31'h0, rx_freq_sel});
    if (air_ign) begin
      wait_tx(1'b0);
      air_q.delete();
      air_ign = 1'b0;
    end else drain();
  endtask
  // compares every read, and every air byte while air_ign is clear, against the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready)
      check("pslverr", 32'h0, {31'h0, pslverr});
    if (psel && penable && pready && !pwrite) begin
      if (rd_q.size() == 0) check("read note", 32'h1, 32'h0);
      else check("prdata", rd_q.pop_front(), prdata);
    end
    if (air_tx_valid === 1'b1 && !air_ign) begin
      if (air_q.size() == 0) check("air note", 32'h1, 32'h0);
      else check("air byte", {24'h0, air_q.pop_front()}, {24'h0, air_tx_data});
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {factory_rx_only, start, frame_cyc, fec_cfg, air_ign} = '0;
    err_count   = 0;
    comparisons = 0;
    n = $urandom(32'hC8B3);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h000, 32'h0);
    rd(12'h014, 32'h3E8);
    repeat (16) apb(12'h008, 1'b1, $urandom);
    rd(12'h008, 32'h0);
    apb(12'h004, 1'b1, 32'h0);
    peer(8'd200);
    send(3, 2'd0);
    @(negedge pclk);
    check("tx_on", 32'h1, {31'h0, tx_on});
    drain();
    apb(12'h000, 1'b1, 32'h8);
    peer(8'd80);
    send(1, 2'd0);
    cyc = 0;
    for (n = 0; n < 100 && air_carrier === 1'b1; n++) begin
      @(negedge pclk);
      if (tx_on === 1'b1) cyc++;
    end
    check("tx during reception", 32'h0, 32'(cyc));
    drain();
    apb(12'h004, 1'b1, 32'd2);
    lat(32'h0, 18);
    for (k = 2; k < 4; k++) begin
      apb(12'h000, 1'b1, 32'(k) << 5);
      send(4, 2'(k));
      drain();
    end
    apb(12'h004, 1'b1, 32'h0);
    lat(32'h101, 13);
    apb(12'h000, 1'b1, 32'h0);
    b = 8'($urandom);
    apb(12'h024, 1'b1, {23'h0, 1'b1, b});
    rd(12'h020, {23'h0, 1'b1, b});
    apb(12'h000, 1'b1, 32'h10);
    @(negedge pclk);
    check("fec_on", 32'h1, {31'h0, fec_on});
    apb(12'h024, 1'b1, {23'h0, 1'b1, b});
    rd(12'h020, 32'h0);
    apb(12'h000, 1'b1, 32'h20);
    c8 = 8'h00;
    for (k = 0; k < 18; k++) begin
      b = (k == 8) ? c8 : (k == 17) ? ~c8 : 8'($urandom);
      if (k < 8) msg.push_back(b);
      c8 = (k == 8) ? 8'h00 : crc8(c8, b);
      apb(12'h024, 1'b1, {23'h0, k == 17, b});
    end
    foreach (msg[i]) rd(12'h020, {23'h0, 1'b1, msg[i]});
    rd(12'h020, 32'h0);
    apb(12'h018, 1'b1, 32'd85);
    apb(12'h000, 1'b1, 32'h80);
    b = 8'($urandom);
    apb(12'h024, 1'b1, {23'h0, 1'b1, b});
    s = "RSSI:-085 dBm";
    rd(12'h020, {23'h0, 1'b1, b});
    rd(12'h020, 32'h102);
    foreach (s[i]) rd(12'h020, {23'h0, 1'b1, s[i]});
    rd(12'h020, 32'h103);
    apb(12'h000, 1'b1, 32'h4);
    rd(12'h014, 32'h0);
    factory_rx_only <= 1'b1;
    apb(12'h000, 1'b1, 32'h0);
    rd(12'h014, 32'h0);
    apb(12'h01C, 1'b1, 32'hA5);
    repeat (150) @(negedge pclk);
    check("rx only tx_on", 32'h0, {31'h0, tx_on});
    report_and_stop();
  end
endmodule
bind rlpc_top rlpc_monitor #(.ENC_LAT_CYC(ENC_LAT_CYC),
  .SPLIT_DLY_CYC(SPLIT_DLY_CYC), .CYC_PER_MS(CYC_PER_MS)) u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .factory_rx_only(factory_rx_only),
  .air_carrier(air_carrier), .tx_on(tx_on), .fec_on(fec_on),
  .air_tx_valid(air_tx_valid));
